/* File: hdl/gpio_ctl_params.svh */
// Offsets, field positions, reset values and codes of the pin control block.
// Included by gpio_pin_control_input only; holds definitions only.
`ifndef GPIO_CTL_PARAMS_SVH
`define GPIO_CTL_PARAMS_SVH

// ==========================================================
// Management address map
`define MGMT_ADDR_W        5
`define MGMT_DATA_W        16
`define PAGE_SEL_ADDR      5'h1F
`define PAGE_MAIN          16'h0000
`define PAGE_GENERAL       16'h0010
`define PIN_CTL_TWO_ADDR   5'h0E
`define PIN_INPUT_ADDR     5'h0F

// ==========================================================
// Fields of pin_control_two
`define HI_SEL_LSB         14
`define HOLD_OE_N_BIT      13
`define HOLD_OUT_BIT       12
`define HOLD_IN_BIT        11
`define RSVD_RW_BIT        10
`define LED_TRI_BIT        9
`define RSVD_RO_BIT        8
`define SEL_HANDOVER       2'h3
`define PIN_CTL_TWO_RESET  16'h2400

// ==========================================================
// Pins
`define GENERAL_PIN_COUNT  15
`define FIRST_SELECT_PIN   8

`endif

/* File: hdl/gpio_ctl_pkg.sv */
// Types shared by the pin control block.
// Assumes nothing of its surroundings.
package gpio_ctl_pkg;

  // Which management page the page-select register currently names
  typedef enum logic [1:0] {
    page_main_type_val,
    page_general_type_val,
    page_other_type_val
  } mgmt_page_type;

  // Two-bit pin selector code
  typedef logic [1:0] pin_sel_type;

endpackage

/* File: hdl/gpio_pin_control_input.sv */
// Pin control register and pin-input snapshot on the paged management space.
// Assumes a management front end that turns serial frames into one-cycle
// read and write strobes on ref_clk; pins are asynchronous.
// soft_rst is a same-clock level from the port's own reset logic; it
// returns the page selector to the main page and drops a pin_control_two write made in the same cycle.
//
// Contract
// - Bits 15:14 code 11 hands pins 12-14
// - Bit 13 low-active power-hold output enable
// - Bit 12 drives power-hold pin when output
// - Bit 11 reads power-hold pin, write ignored
// - Bit 9 set: LEDs float instead of high
// - Pairs 7:0 code 11 hand pins 11-8
// - Input register shows pins 14-0 levels
// - One shared page, survives software reset
`timescale 1ns/100ps
`include "gpio_ctl_params.svh"
module gpio_pin_control_input
  import gpio_ctl_pkg::*;
#(
  parameter int PIN_COUNT = `GENERAL_PIN_COUNT
)
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    soft_rst,
  // Management register access
  input  wire logic [`MGMT_ADDR_W-1:0] mgmt_addr,
  input  wire logic                    mgmt_wr,
  input  wire logic [`MGMT_DATA_W-1:0] mgmt_wdata,
  input  wire logic                    mgmt_rd,
  output logic      [`MGMT_DATA_W-1:0] mgmt_rdata,
  output logic                         mgmt_rvalid,
  // General purpose pins
  input  wire logic [PIN_COUNT-1:0]    general_pin_in,
  output logic      [PIN_COUNT-1:0]    pin_handover,
  // Power-hold pin
  input  wire logic                    power_hold_pin_in,
  output logic                         power_hold_pin_out,
  output logic                         power_hold_pin_oe_n,
  // LED output style
  output logic                         led_tristate
);

  generate
    if (PIN_COUNT != `GENERAL_PIN_COUNT)
    begin : g_bad_count
      $error("gpio_pin_control_input: PIN_COUNT must be 15");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers

  logic [PIN_COUNT-1:0] pin_level;
  logic                 hold_level;

  level_sync #(
    .WIDTH    (PIN_COUNT + 1)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({power_hold_pin_in, general_pin_in}),
    .sync_out ({hold_level, pin_level})
  );

  // ==========================================================
  // Decoding

  function automatic mgmt_page_type page_of(input logic [15:0] value);
    if (value == `PAGE_MAIN)
      page_of = page_main_type_val;
    else if (value == `PAGE_GENERAL)
      page_of = page_general_type_val;
    else
      page_of = page_other_type_val;
  endfunction

  // Reserved selector codes leave the pin with nobody
  function automatic logic handed(input pin_sel_type code);
    handed = (code == `SEL_HANDOVER);
  endfunction

  // ==========================================================
  // Register state

  logic [`MGMT_DATA_W-1:0] page_reg;
  logic [`MGMT_DATA_W-1:0] page_next;
  logic [`MGMT_DATA_W-1:0] ctl_reg;
  logic [`MGMT_DATA_W-1:0] ctl_next;
  logic [`MGMT_DATA_W-1:0] rdata_reg;
  logic [`MGMT_DATA_W-1:0] rdata_next;
  logic                    rvalid_reg;
  logic                    rvalid_next;
  logic [PIN_COUNT-1:0]    handover_reg;
  logic [PIN_COUNT-1:0]    handover_next;
  logic                    hold_out_reg;
  logic                    hold_out_next;
  logic                    hold_oe_n_reg;
  logic                    hold_oe_n_next;
  logic                    led_tri_reg;
  logic                    led_tri_next;
  logic                    in_general;
  logic [`MGMT_DATA_W-1:0] ctl_view;
  logic [`MGMT_DATA_W-1:0] input_view;

  assign in_general = (page_of(page_reg) == page_general_type_val);

  always_comb
  begin
    page_next = page_reg;
    ctl_next  = ctl_reg;

    // Software reset returns to the main page and drops a same-cycle control write; the shared page keeps
    // its bits, since all four ports see the same copy
    if (soft_rst)
      page_next = `PAGE_MAIN;
    else if (mgmt_wr && mgmt_addr == `PAGE_SEL_ADDR)
      page_next = mgmt_wdata;

    if (!soft_rst && mgmt_wr && in_general
        && mgmt_addr == `PIN_CTL_TWO_ADDR)
    begin
      ctl_next = mgmt_wdata;
      // Read-only positions keep zero; the pin level is merged on read
      ctl_next[`HOLD_IN_BIT] = 1'h0;
      ctl_next[`RSVD_RO_BIT] = 1'h0;
    end
  end

  // Read view of the control register with the live pin level in bit 11
  always_comb
  begin
    ctl_view               = ctl_reg;
    ctl_view[`HOLD_IN_BIT] = hold_level;
    input_view             = '0;
    input_view[PIN_COUNT-1:0] = pin_level;
  end

  always_comb
  begin
    rvalid_next = mgmt_rd;
    rdata_next  = rdata_reg;
    if (mgmt_rd)
    begin
      if (mgmt_addr == `PAGE_SEL_ADDR)
        rdata_next = page_reg;
      else if (in_general && mgmt_addr == `PIN_CTL_TWO_ADDR)
        rdata_next = ctl_view;
      else if (in_general && mgmt_addr == `PIN_INPUT_ADDR)
        rdata_next = input_view;
      else
        rdata_next = '0;
    end
  end

  // ==========================================================
  // Pin-side outputs, taken from the stored control bits

  always_comb
  begin
    handover_next = '0;
    for (int i = 0; i < 4; i++)
      handover_next[`FIRST_SELECT_PIN + i] =
        handed(ctl_reg[2*i +: 2]);
    for (int i = 12; i < PIN_COUNT; i++)
      handover_next[i] = handed(ctl_reg[`HI_SEL_LSB +: 2]);
    hold_oe_n_next = ctl_reg[`HOLD_OE_N_BIT];
    // Data held at zero while the pin is an input avoids a stray level
    hold_out_next  = ctl_reg[`HOLD_OUT_BIT]
                     & ~ctl_reg[`HOLD_OE_N_BIT];
    led_tri_next   = ctl_reg[`LED_TRI_BIT];
  end

  // Register bus state
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      page_reg   <= `PAGE_MAIN;
      ctl_reg    <= `PIN_CTL_TWO_RESET;
      rdata_reg  <= '0;
      rvalid_reg <= 1'h0;
    end
    else
    begin
      page_reg   <= page_next;
      ctl_reg    <= ctl_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Pin-side state; reset levels match the control reset, so the pins
  // stay calm between reset and the first decoded edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      handover_reg  <= '0;
      hold_out_reg  <= 1'h0;
      hold_oe_n_reg <= 1'h1;
      led_tri_reg   <= 1'h0;
    end
    else
    begin
      handover_reg  <= handover_next;
      hold_out_reg  <= hold_out_next;
      hold_oe_n_reg <= hold_oe_n_next;
      led_tri_reg   <= led_tri_next;
    end
  end

  // ==========================================================
  // Outputs, each straight from its register

  assign mgmt_rdata          = rdata_reg;
  assign mgmt_rvalid         = rvalid_reg;
  assign pin_handover        = handover_reg;
  assign power_hold_pin_out  = hold_out_reg;
  assign power_hold_pin_oe_n = hold_oe_n_reg;
  assign led_tristate        = led_tri_reg;

endmodule

/* File: hdl/level_sync.sv */
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level from a pin; no bus coherence implied.
`timescale 1ns/100ps
module level_sync
  import gpio_ctl_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("level_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage is read only by the second stage
  logic [WIDTH-1:0] stage_one_reg;
  logic [WIDTH-1:0] stage_two_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage_one_reg <= '0;
      stage_two_reg <= '0;
    end
    else
    begin
      stage_one_reg <= async_in;
      stage_two_reg <= stage_one_reg;
    end
  end

  assign sync_out = stage_two_reg;

endmodule

/* File: tb/gpio_ctl_assertions.sv */
// Port-level checker for the pin control block.
// Bound to gpio_pin_control_input; sees only its ports.
`timescale 1ns/100ps
module gpio_ctl_checker #(
  parameter int PIN_COUNT = 15
)
(
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 soft_rst,
  // Management access
  input wire logic [4:0]           mgmt_addr,
  input wire logic                 mgmt_wr,
  input wire logic [15:0]          mgmt_wdata,
  input wire logic                 mgmt_rd,
  input wire logic [15:0]          mgmt_rdata,
  input wire logic                 mgmt_rvalid,
  // Pins
  input wire logic [PIN_COUNT-1:0] general_pin_in,
  input wire logic [PIN_COUNT-1:0] pin_handover,
  input wire logic                 power_hold_pin_in,
  input wire logic                 power_hold_pin_out,
  input wire logic                 power_hold_pin_oe_n,
  input wire logic                 led_tristate
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions
  chk_rvalid_after_rd: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read answer missing");
  chk_rvalid_only_rd: assert property (!mgmt_rd |=> !mgmt_rvalid)
    else $error("read answer without read");
  chk_rdata_hold: assert property (!mgmt_rd |=> $stable(mgmt_rdata))
    else $error("read data moved without read");
  chk_input_top_zero: assert property
    (mgmt_rd && mgmt_addr == 5'h0F |=> !mgmt_rdata[15])
    else $error("reserved input bit set");
  chk_out_needs_oe: assert property
    (power_hold_pin_out |-> !power_hold_pin_oe_n)
    else $error("hold pin driven while input");
  chk_oe_cause: assert property
    ($changed(power_hold_pin_oe_n) |-> $past(mgmt_wr, 2))
    else $error("hold pin enable moved without write");
  chk_led_cause: assert property
    ($changed(led_tristate) |-> $past(mgmt_wr, 2))
    else $error("led style moved without write");
  chk_low_pins_off: assert property (pin_handover[7:0] == 8'h00)
    else $error("low pin handed over");
  chk_upper_group: assert property
    (pin_handover[14:12] == 3'h0 || pin_handover[14:12] == 3'h7)
    else $error("upper pins split");
  cov_input_read: cover property (mgmt_rd && mgmt_addr == 5'h0F);
  cov_hold_drive: cover property ($fell(power_hold_pin_oe_n));
  cov_led_float: cover property ($rose(led_tristate));
endmodule

bind gpio_pin_control_input gpio_ctl_checker #(.PIN_COUNT(PIN_COUNT))
  u_gpio_ctl_checker (.*);

/* File: tb/tb_gpio_pin_control_input.sv */
// Self-checking bench for the pin control block.
// Drives strobes and pins itself; no far-side model.
`timescale 1ns/100ps
module tb_gpio_pin_control_input;
  logic        ref_clk = 1'h0, rst = 1'h1, soft_rst = 1'h0;
  logic [4:0]  mgmt_addr = 5'h00;
  logic        mgmt_wr = 1'h0, mgmt_rd = 1'h0, mgmt_rvalid;
  logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, rv;
  logic        power_hold_pin_in = 1'h0, power_hold_pin_out;
  logic        power_hold_pin_oe_n, led_tristate;
  logic [14:0] general_pin_in = 15'h0000, pin_handover;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  gpio_pin_control_input u_gpio_pin_control_input (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .soft_rst            (soft_rst),
    .mgmt_addr           (mgmt_addr),
    .mgmt_wr             (mgmt_wr),
    .mgmt_wdata          (mgmt_wdata),
    .mgmt_rd             (mgmt_rd),
    .mgmt_rdata          (mgmt_rdata),
    .mgmt_rvalid         (mgmt_rvalid),
    .general_pin_in      (general_pin_in),
    .pin_handover        (pin_handover),
    .power_hold_pin_in   (power_hold_pin_in),
    .power_hold_pin_out  (power_hold_pin_out),
    .power_hold_pin_oe_n (power_hold_pin_oe_n),
    .led_tristate        (led_tristate)
  );
  always #12.5 ref_clk = ~ref_clk;
  // ==========================================================
  // Shared tasks
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    mgmt_wr <= 1'h1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge ref_clk);
    mgmt_wr <= 1'h0;
    // Pin outputs follow two edges after the write
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task rd(input logic [4:0] a);
    @(posedge ref_clk);
    mgmt_rd <= 1'h1;
    mgmt_addr <= a;
    @(posedge ref_clk);
    mgmt_rd <= 1'h0;
    // Answer stands for the one cycle after the strobe
    @(negedge ref_clk);
    chk({15'h0000, mgmt_rvalid}, 16'h0001);
    rv = mgmt_rdata;
    @(negedge ref_clk);
    chk({15'h0000, mgmt_rvalid}, 16'h0000);
  endtask
  task outs(input logic [15:0] h, input logic [2:0] p);
    logic [2:0] s;
    s = {power_hold_pin_oe_n, power_hold_pin_out, led_tristate};
    chk({1'h0, pin_handover}, h);
    chk({13'h0000, s}, {13'h0000, p});
  endtask
  task set_pins(input logic h, input logic [14:0] g);
    @(posedge ref_clk);
    power_hold_pin_in <= h;
    general_pin_in <= g;
    // Two synchroniser stages before a read can see the level
    repeat (2) @(posedge ref_clk);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    @(negedge ref_clk);
    outs(16'h0000, 3'h4);
    rd(5'h1F);
    chk(rv, 16'h0000);
    rd(5'h0E);
    chk(rv, 16'h0000);
    wr(5'h1F, 16'h0010);
    rd(5'h0E);
    chk(rv, 16'h2400);
  endtask
  task t_all_ones;
    set_pins(1'h1, 15'h0000);
    wr(5'h0E, 16'hFFFF);
    rd(5'h0E);
    chk(rv, 16'hFEFF);
    outs(16'h7F00, 3'h5);
  endtask
  task t_drive;
    set_pins(1'h0, 15'h0000);
    wr(5'h0E, 16'h1400);
    outs(16'h0000, 3'h2);
    rd(5'h0E);
    chk(rv, 16'h1400);
    wr(5'h0E, 16'h0400);
    outs(16'h0000, 3'h0);
  endtask
  task t_selectors;
    for (int c = 0; c < 4; c++)
    begin
      wr(5'h0E, {c[1:0], 6'h24, c[1:0], 4'h0, c[1:0]});
      chk({1'h0, pin_handover}, c == 3 ? 16'h7900 : 16'h0000);
    end
  endtask
  task t_inputs;
    set_pins(1'h0, 15'h2A5C);
    rd(5'h0F);
    chk(rv, 16'h2A5C);
    set_pins(1'h0, 15'h55A3);
    wr(5'h0F, 16'hFFFF);
    rd(5'h0F);
    chk(rv, 16'h55A3);
  endtask
  task t_soft;
    @(posedge ref_clk);
    soft_rst <= 1'h1;
    @(posedge ref_clk);
    soft_rst <= 1'h0;
    rd(5'h0E);
    chk(rv, 16'h0000);
    wr(5'h1F, 16'h0010);
    rd(5'h0E);
    chk(rv, 16'hE4C3);
    wr(5'h1F, 16'h0000);
    rd(5'h0E);
    chk(rv, 16'h0000);
  endtask
  // ==========================================================
  // Sequence and verdict
  task close_out;
    $display("mismatches %0d of %0d compares", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out;
    end
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset;
    t_all_ones;
    t_drive;
    t_selectors;
    t_inputs;
    t_soft;
    close_out;
  end
endmodule
